// ### shared/mpi_pkg.sv
// Constants and register map of the multimode pulse input unit
package mpi_pkg;
  // Clock and time base
  localparam int CLK_HZ = 25_000_000;
  localparam int US_PER_S = 1_000_000;
  localparam int US_TICK_CYCLES = CLK_HZ / US_PER_S;
  localparam logic [4:0] US_TICK_LAST = 5'(US_TICK_CYCLES - 1);
  // Longest frequency interval, one second in microseconds
  localparam int FREQ_MAX_INTERVAL_S = 1;
  localparam logic [19:0] FREQ_BASE_US = 20'(FREQ_MAX_INTERVAL_S * US_PER_S);
  localparam int NCH = 8;

  // Register byte offsets
  localparam logic [11:0] REG_PIN_STATE = 12'h000;
  localparam logic [11:0] REG_FREQ_INTERVAL = 12'h004;
  localparam logic [11:0] REG_IRQ_STATUS = 12'h008;
  localparam logic [11:0] REG_IRQ_MASK = 12'h00C;
  localparam logic [11:0] REG_CH_CONFIG_BASE = 12'h100;
  localparam logic [11:0] REG_CH_RESULT_BASE = 12'h200;

  // Channel config field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_EDGE_LSB = 4;
  localparam int CFG_TSEL_LSB = 6;
  localparam int CFG_CAPSRC_BIT = 8;
  localparam int CFG_SRCCH_LSB = 9;
  localparam int CFG_WIDTH = 12;

  // Channel modes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_COUNT = 3'h1;
  localparam logic [2:0] MODE_FREQ = 3'h2;
  localparam logic [2:0] MODE_TIMING = 3'h3;
  localparam logic [2:0] MODE_CAPTURE = 3'h4;
  localparam logic [2:0] MODE_QUAD = 3'h5;
  localparam logic [2:0] MODE_PULSE_DIR = 3'h6;

  // Edge select and timing select codes
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] TSEL_PERIOD_RISE = 2'h0;
  localparam logic [1:0] TSEL_PERIOD_FALL = 2'h1;
  localparam logic [1:0] TSEL_HIGH = 2'h2;
  localparam logic [1:0] TSEL_LOW = 2'h3;

  // Reset values
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 12'h000;
  localparam logic [2:0] IVAL_RESET = 3'h0;
  localparam logic [8:0] MASK_RESET = 9'h000;
  localparam int IRQ_IVAL_BIT = 8;
endpackage

// ### verilog/mpi_unit.sv
// Multimode pulse input unit: counters, encoders, frequency, timing and capture over APB
// Contract
// - Quadrature counts every edge of both phases
// - Encoders only on pairs 1-2,3-4,5-6,7-8
// - Counter counts rising, falling or both edges
// - Frequency reported in one hertz units
// - Interval programmable, at most one second
// - Frequency read holds last completed interval
// - Timing measures period or pulse in microseconds
// - Capture timestamps selected edges in microseconds
// - Capture read returns latest event, overwriting
// - Capture may latch another channel's count
// - Pin levels readable in every mode
// - Reluctance channels share all general functions
// - Handles one hertz to twenty-five kilohertz
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
module mpi_unit
  import mpi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] general_pulse_input,
  input wire logic [1:0] reluctance_pulse_input,
  output logic irq
);

  // Channels 7 and 8 are fed from the reluctance front end, same logic as the rest
  logic [NCH-1:0] pin_raw;
  assign pin_raw = {reluctance_pulse_input, general_pulse_input};

  // Two-flop synchronizer, then an edge-detect history stage
  logic [NCH-1:0] sync1;
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] prv;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      lvl <= '0;
      prv <= '0;
    end
    else
    begin
      sync1 <= pin_raw;
      lvl <= sync1;
      prv <= lvl;
    end
  end

  // Microsecond tick, free-running timestamp and frequency interval
  logic [4:0] div;
  logic [31:0] us_time;
  logic [19:0] ival_cnt;
  logic [2:0] ival_sel;
  logic tick;
  logic ival_done;
  logic [19:0] ival_len;
  logic [4:0] next_div;
  logic [31:0] next_us_time;
  logic [19:0] next_ival_cnt;
  always_comb
  begin
    tick = (div == US_TICK_LAST);
    next_div = tick ? 5'h00 : div + 5'h01;
    next_us_time = tick ? us_time + 32'h1 : us_time;
    // Shorter intervals are the one-second base halved sel times
    ival_len = FREQ_BASE_US >> ival_sel;
    ival_done = tick && (ival_cnt >= ival_len - 20'h1);
    next_ival_cnt = ival_cnt;
    if (ival_done)
      next_ival_cnt = 20'h0;
    else if (tick)
      next_ival_cnt = ival_cnt + 20'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div <= 5'h00;
      us_time <= 32'h0;
      ival_cnt <= 20'h0;
    end
    else
    begin
      div <= next_div;
      us_time <= next_us_time;
      ival_cnt <= next_ival_cnt;
    end
  end

  // Per-channel state, shared so capture can read any channel's count
  logic [CFG_WIDTH-1:0] cfg [NCH];
  logic [31:0] cnt [NCH];
  logic [31:0] res [NCH];
  logic [31:0] view [NCH];
  logic ch_evt [NCH];
  logic ld_en [NCH];

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      localparam int HI = (gi % 2 == 0) ? gi + 1 : gi;
      localparam int LO = (gi % 2 == 0) ? gi : gi - 1;
      logic [2:0] mode_raw;
      logic [2:0] mode_lo;
      logic [2:0] mode;
      logic [1:0] esel;
      logic [1:0] tsel;
      logic rise;
      logic fall;
      logic hit;
      logic [31:0] tmr;
      logic [31:0] edg;
      logic [31:0] next_cnt;
      logic [31:0] next_res;
      logic [31:0] next_tmr;
      logic [31:0] next_edg;
      logic evt;

      assign mode_raw = cfg[gi][CFG_MODE_LSB +: 3];
      assign mode_lo = cfg[LO][CFG_MODE_LSB +: 3];
      assign esel = cfg[gi][CFG_EDGE_LSB +: 2];
      assign tsel = cfg[gi][CFG_TSEL_LSB +: 2];
      assign rise = lvl[gi] & ~prv[gi];
      assign fall = ~lvl[gi] & prv[gi];
      // Selected edge for counting, pulse stepping and capture
      assign hit = (rise && esel[0]) || (fall && esel[1]);

      // Encoder modes live only on the lower channel of a fixed pair
      always_comb
      begin
        mode = mode_raw;
        if (gi % 2 == 1)
        begin
          if (mode_raw == MODE_QUAD || mode_raw == MODE_PULSE_DIR)
            mode = MODE_OFF;
          if (mode_lo == MODE_QUAD || mode_lo == MODE_PULSE_DIR)
            mode = MODE_OFF;
        end
      end

      // Next state of counter, result, microsecond timer and edge tally
      always_comb
      begin
        next_cnt = cnt[gi];
        next_res = res[gi];
        next_tmr = tmr;
        next_edg = edg;
        evt = 1'b0;
        // Timer saturates rather than wrapping into a short false reading
        if (tick && tmr != 32'hFFFFFFFF)
          next_tmr = tmr + 32'h1;
        case (mode)
          MODE_COUNT:
          begin
            if (hit)
            begin
              next_cnt = cnt[gi] + 32'h1;
              evt = 1'b1;
            end
          end
          MODE_FREQ:
          begin
            if (ival_done)
            begin
              // Scale back to hertz; a rise now belongs to the new interval
              next_res = edg << ival_sel;
              next_edg = rise ? 32'h1 : 32'h0;
              evt = 1'b1;
            end
            else if (rise)
              next_edg = edg + 32'h1;
          end
          MODE_TIMING:
          begin
            case (tsel)
              TSEL_PERIOD_RISE:
              begin
                if (rise)
                begin
                  next_res = tmr;
                  next_tmr = 32'h0;
                  evt = 1'b1;
                end
              end
              TSEL_PERIOD_FALL:
              begin
                if (fall)
                begin
                  next_res = tmr;
                  next_tmr = 32'h0;
                  evt = 1'b1;
                end
              end
              TSEL_HIGH:
              begin
                if (rise)
                  next_tmr = 32'h0;
                if (fall)
                begin
                  next_res = tmr;
                  evt = 1'b1;
                end
              end
              default:
              begin
                if (fall)
                  next_tmr = 32'h0;
                if (rise)
                begin
                  next_res = tmr;
                  evt = 1'b1;
                end
              end
            endcase
          end
          MODE_CAPTURE:
          begin
            if (hit)
            begin
              // Latest event overwrites; source count or timestamp
              if (cfg[gi][CFG_CAPSRC_BIT])
                next_res = cnt[cfg[gi][CFG_SRCCH_LSB +: 3]];
              else
                next_res = us_time;
              evt = 1'b1;
            end
          end
          MODE_QUAD:
          begin
            // Exactly one phase changed: a legal step; both changed is dropped
            if ((lvl[gi] ^ prv[gi]) != (lvl[HI] ^ prv[HI]))
            begin
              if (lvl[gi] ^ prv[HI])
                next_cnt = cnt[gi] + 32'h1;
              else
                next_cnt = cnt[gi] - 32'h1;
              evt = 1'b1;
            end
          end
          MODE_PULSE_DIR:
          begin
            // Pulse on the lower pin, direction level on the higher pin
            if (hit)
            begin
              if (lvl[HI])
                next_cnt = cnt[gi] + 32'h1;
              else
                next_cnt = cnt[gi] - 32'h1;
              evt = 1'b1;
            end
          end
          default:
          begin
            next_tmr = tmr;
          end
        endcase
        // Software preset of the counter wins over a simultaneous step
        if (ld_en[gi])
          next_cnt = pwdata;
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          cnt[gi] <= 32'h0;
          res[gi] <= 32'h0;
          tmr <= 32'h0;
          edg <= 32'h0;
        end
        else
        begin
          cnt[gi] <= next_cnt;
          res[gi] <= next_res;
          tmr <= next_tmr;
          edg <= next_edg;
        end
      end

      assign ch_evt[gi] = evt;
      // Counting modes read the live count, measuring modes the held result
      assign view[gi] = (mode == MODE_COUNT || mode == MODE_QUAD || mode == MODE_PULSE_DIR) ? cnt[gi] : res[gi];
    end
  endgenerate

  // APB slave, interrupt status and mask
  logic [8:0] status;
  logic [8:0] mask;
  logic [CFG_WIDTH-1:0] next_cfg [NCH];
  logic [2:0] next_ival_sel;
  logic [8:0] next_status;
  logic [8:0] next_mask;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;
  logic acc;
  logic wr;
  logic [2:0] idx;
  logic [8:0] set_bits;
  logic [8:0] clr_bits;
  logic mapped;

  always_comb
  begin
    acc = psel && penable;
    wr = acc && pready && pwrite;
    idx = paddr[4:2];
    next_ival_sel = ival_sel;
    next_mask = mask;
    next_prdata = prdata;
    clr_bits = 9'h000;
    mapped = 1'b1;
    for (int k = 0; k < NCH; k++)
    begin
      next_cfg[k] = cfg[k];
      ld_en[k] = 1'b0;
      set_bits[k] = ch_evt[k];
    end
    set_bits[IRQ_IVAL_BIT] = ival_done;
    // Decode the word address; low address bits must be zero
    if (paddr[1:0] != 2'h0)
      mapped = 1'b0;
    else if (paddr == REG_PIN_STATE)
      next_prdata = {24'h0, lvl};
    else if (paddr == REG_FREQ_INTERVAL)
    begin
      next_prdata = {29'h0, ival_sel};
      if (wr)
        next_ival_sel = pwdata[2:0];
    end
    else if (paddr == REG_IRQ_STATUS)
    begin
      next_prdata = {23'h0, status};
      if (wr)
        clr_bits = pwdata[8:0];
    end
    else if (paddr == REG_IRQ_MASK)
    begin
      next_prdata = {23'h0, mask};
      if (wr)
        next_mask = pwdata[8:0];
    end
    else if (paddr[11:5] == REG_CH_CONFIG_BASE[11:5])
    begin
      next_prdata = {20'h0, cfg[idx]};
      if (wr)
        next_cfg[idx] = pwdata[CFG_WIDTH-1:0];
    end
    else if (paddr[11:5] == REG_CH_RESULT_BASE[11:5])
    begin
      next_prdata = view[idx];
      if (wr)
        ld_en[idx] = 1'b1;
    end
    else
      mapped = 1'b0;
    // One wait state: data and error are registered on the same edge that raises pready
    next_pready = acc && !pready;
    next_pslverr = acc && !pready && !mapped;
    if (!(acc && !pready))
      next_prdata = prdata;
    // Hardware set wins over a write-one clear in the same cycle
    next_status = (status & ~clr_bits) | set_bits;
    next_irq = |(next_status & mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int k = 0; k < NCH; k++)
        cfg[k] <= CFG_RESET;
      ival_sel <= IVAL_RESET;
      status <= 9'h000;
      mask <= MASK_RESET;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      for (int k = 0; k < NCH; k++)
        cfg[k] <= next_cfg[k];
      ival_sel <= next_ival_sel;
      status <= next_status;
      mask <= next_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

endmodule

// ### verification/mpi_sensor_model.sv
// Sensor bank model driving the eight pulse channels
`timescale 1ns/1ps
module mpi_sensor_model (
  input wire logic pclk,
  output logic [5:0] general_pulse_input,
  output logic [1:0] reluctance_pulse_input
);
  logic [7:0] pin = 8'h00;
  // A sensor holds its level between edges
  assign {reluctance_pulse_input, general_pulse_input} = pin;
  task automatic put(input logic [7:0] v);
    pin <= v;
  endtask
  // Each edge waits gap clocks first; callers pass gaps of 10 or 500
  task automatic toggle(input int ch, input int n, input int gap);
    repeat (n)
    begin
      repeat (gap) @(posedge pclk);
      pin[ch] <= ~pin[ch];
    end
  endtask
  task automatic wave(input int ch, input int n, input int hi, input int lo);
    repeat (n)
    begin
      pin[ch] <= 1'b1;
      repeat (hi) @(posedge pclk);
      pin[ch] <= 1'b0;
      repeat (lo) @(posedge pclk);
    end
  endtask
  // Phases on one fixed pair; lower channel leads when moving up
  task automatic quad(input int lo, input int n, input bit up);
    repeat (n)
    begin
      repeat (250) @(posedge pclk);
      if ((pin[lo] == pin[lo+1]) == up)
        pin[lo] <= ~pin[lo];
      else
        pin[lo+1] <= ~pin[lo+1];
    end
  endtask
  // Both phases at once: a broken encoder step
  task automatic flip(input int lo);
    repeat (250) @(posedge pclk);
    pin[lo+:2] <= ~pin[lo+:2];
  endtask
endmodule

// ### verification/mpi_unit_monitor.sv
// Checker of the bus handshake, pin readback and interrupt mask
`timescale 1ns/1ps
module mpi_unit_monitor
  import mpi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] general_pulse_input,
  input wire logic [1:0] reluctance_pulse_input,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase opens, ready comes one cycle later for one cycle
  sequence s_open;
    psel && penable && !$past(penable);
  endsequence
  sequence s_answer;
    !pready ##1 pready ##1 !pready;
  endsequence
  // Pins quiet long enough to cross both sync stages
  sequence s_quiet;
    ($stable(general_pulse_input) && $stable(reluctance_pulse_input)) [*6];
  endsequence
  a_ready_timed: assert property (s_open |-> s_answer) else $error("ready timing wrong");
  a_ready_scope: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_align: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned accepted");
  a_err_unmap: assert property (pready && paddr >= 12'h220 |-> pslverr) else $error("unmapped accepted");
  a_data_hold: assert property (!pready |-> $stable(prdata)) else $error("read data moved");
  a_pin_readback: assert property (s_quiet ##0 (pready && !pwrite && paddr == REG_PIN_STATE) |->
    prdata[7:0] == {reluctance_pulse_input, general_pulse_input}) else $error("pin level wrong");
  a_irq_masked: assert property (pready && pwrite && !pslverr && paddr == REG_IRQ_MASK && pwdata[8:0] == 9'h000
    |-> ##2 !irq) else $error("masked irq high");
endmodule
bind mpi_unit mpi_unit_monitor u_mon (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .general_pulse_input(general_pulse_input), .reluctance_pulse_input(reluctance_pulse_input), .irq(irq));

// ### verification/test_multimode_pulse_input_unit.sv
// Self-checking bench of the multimode pulse input unit
`timescale 1ns/1ps
module test_multimode_pulse_input_unit
  import mpi_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] general_pulse_input;
  logic [1:0] reluctance_pulse_input;
  logic irq;
  logic [31:0] rdat;
  logic rerr;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  initial
  begin
    forever #20 pclk = ~pclk;
  end
  mpi_unit DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .general_pulse_input(general_pulse_input), .reluctance_pulse_input(reluctance_pulse_input), .irq(irq));
  mpi_sensor_model sensors (.pclk(pclk), .general_pulse_input(general_pulse_input),
    .reluctance_pulse_input(reluctance_pulse_input));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One transfer; request held until ready is sampled high, only the cycle ceiling ends a wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rdat, exp);
  endtask
  function automatic logic [11:0] cfg(input int ch);
    return REG_CH_CONFIG_BASE + 12'(4 * ch);
  endfunction
  function automatic logic [11:0] res(input int ch);
    return REG_CH_RESULT_BASE + 12'(4 * ch);
  endfunction
  function automatic logic [31:0] mk(input logic [2:0] m, input logic [1:0] e, input logic [1:0] t);
    return 32'(m) | (32'(e) << CFG_EDGE_LSB) | (32'(t) << CFG_TSEL_LSB);
  endfunction
  task automatic t_regs();
    rd("interval", REG_FREQ_INTERVAL, 32'(IVAL_RESET));
    rd("mask", REG_IRQ_MASK, 32'(MASK_RESET));
    rd("config", cfg(7), 32'(CFG_RESET));
    apb(1'b1, REG_FREQ_INTERVAL, 32'h7);
    rd("interval", REG_FREQ_INTERVAL, 32'h7);
    apb(1'b0, 12'h220, 32'h0);
    check("unmapped", 32'(rerr), 32'h1);
    apb(1'b1, 12'h006, 32'h0);
    check("misaligned", 32'(rerr), 32'h1);
    $display("test regs done");
  endtask
  task automatic t_pins();
    apb(1'b1, cfg(0), mk(MODE_COUNT, 2'h0, 2'h0));
    sensors.put(8'hA5);
    repeat (8) @(posedge pclk);
    rd("pins", REG_PIN_STATE, 32'hA5);
    apb(1'b1, REG_PIN_STATE, 32'h0);
    rd("pins", REG_PIN_STATE, 32'hA5);
    sensors.put(8'h00);
    $display("test pins done");
  endtask
  task automatic t_count();
    logic [1:0] ed[3] = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH};
    int ex[3] = '{2, 2, 4};
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, cfg(0), mk(MODE_COUNT, ed[i], 2'h0));
      apb(1'b1, res(0), 32'h0);
      sensors.toggle(0, 4, 500);
      repeat (8) @(posedge pclk);
      rd("count", res(0), 32'(ex[i]));
    end
    $display("test count done");
  endtask
  // Lower pair general, upper pair reluctance; broken step must not count
  task automatic t_quad();
    int lo[2] = '{0, 6};
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, cfg(lo[i]), mk(MODE_QUAD, 2'h0, 2'h0));
      apb(1'b1, res(lo[i]), 32'h0);
      sensors.quad(lo[i], 8, 1'b1);
      repeat (8) @(posedge pclk);
      rd("quad up", res(lo[i]), 32'h8);
      sensors.quad(lo[i], 3, 1'b0);
      sensors.flip(lo[i]);
      repeat (8) @(posedge pclk);
      rd("quad down", res(lo[i]), 32'h5);
      apb(1'b1, cfg(lo[i]), 32'h0);
    end
    $display("test quad done");
  endtask
  task automatic t_pdir();
    apb(1'b1, cfg(2), mk(MODE_PULSE_DIR, EDGE_BOTH, 2'h0));
    apb(1'b1, res(2), 32'h0);
    sensors.toggle(3, 1, 10);
    sensors.toggle(2, 4, 500);
    repeat (8) @(posedge pclk);
    rd("pdir up", res(2), 32'h4);
    sensors.toggle(3, 1, 10);
    sensors.toggle(2, 2, 500);
    repeat (8) @(posedge pclk);
    rd("pdir down", res(2), 32'h2);
    $display("test pdir done");
  endtask
  // 20 us high, 30 us low, so a 50 us period
  task automatic t_timing();
    logic [1:0] ts[4] = '{TSEL_PERIOD_RISE, TSEL_PERIOD_FALL, TSEL_HIGH, TSEL_LOW};
    int us[4] = '{50, 50, 20, 30};
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, cfg(4), mk(MODE_TIMING, 2'h0, ts[i]));
      sensors.wave(4, 3, 500, 750);
      apb(1'b0, res(4), 32'h0);
      check("timing", 32'(rdat >= us[i] - 1 && rdat <= us[i] + 1), 32'h1);
    end
    $display("test timing done");
  endtask
  task automatic t_capture();
    logic [31:0] r1;
    apb(1'b1, cfg(5), mk(MODE_CAPTURE, EDGE_RISE, 2'h0));
    fork
      sensors.wave(5, 2, 500, 1500);
      begin
        repeat (250) @(posedge pclk);
        apb(1'b0, res(5), 32'h0);
        r1 = rdat;
      end
    join
    apb(1'b0, res(5), 32'h0);
    check("stamp gap", 32'(rdat - r1 >= 79 && rdat - r1 <= 81), 32'h1);
    apb(1'b1, cfg(0), mk(MODE_COUNT, EDGE_RISE, 2'h0));
    apb(1'b1, res(0), 32'h123);
    apb(1'b1, cfg(5), mk(MODE_CAPTURE, EDGE_RISE, 2'h0) | (32'h1 << CFG_CAPSRC_BIT));
    sensors.wave(5, 1, 500, 500);
    rd("captured count", res(5), 32'h123);
    $display("test capture done");
  endtask
  task automatic t_irq();
    apb(1'b1, REG_IRQ_MASK, 32'h0);
    apb(1'b1, REG_IRQ_STATUS, 32'h1FF);
    sensors.toggle(0, 1, 10);
    repeat (8) @(posedge pclk);
    rd("status", REG_IRQ_STATUS, 32'h1);
    check("irq masked", 32'(irq), 32'h0);
    apb(1'b1, REG_IRQ_MASK, 32'h1);
    repeat (3) @(posedge pclk);
    check("irq on", 32'(irq), 32'h1);
    apb(1'b1, REG_IRQ_STATUS, 32'h1);
    repeat (3) @(posedge pclk);
    check("irq off", 32'(irq), 32'h0);
    rd("status", REG_IRQ_STATUS, 32'h0);
    $display("test irq done");
  endtask
  // Interval far longer than the run, so no result may show yet
  task automatic t_freq();
    apb(1'b1, cfg(1), mk(MODE_FREQ, EDGE_RISE, 2'h0));
    sensors.toggle(1, 4, 500);
    rd("freq held", res(1), 32'h0);
    $display("test freq done");
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_pins();
    t_count();
    t_quad();
    t_pdir();
    t_timing();
    t_capture();
    t_irq();
    t_freq();
    give_verdict();
  end
  // Ceiling well above the roughly 40k cycles the tests need
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      errors++;
      give_verdict();
    end
  end
endmodule
